//--- include/sif_cfg.svh
`ifndef SIF_CFG_SVH
`define SIF_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SIF_OFF_CTL1      3'h0
`define SIF_OFF_CTL2      3'h1
`define SIF_OFF_BAUD      3'h2
`define SIF_OFF_STAT      3'h3
`define SIF_OFF_CMP       3'h4
`define SIF_OFF_DATA      3'h5

// ****************************************
// control one bit positions
// ****************************************
`define SIF_C1_RXF_MASK   7
`define SIF_C1_SYS_EN     6
`define SIF_C1_TX_MASK    5
`define SIF_C1_MASTER     4
`define SIF_C1_CLOCK_POLARITY       3
`define SIF_C1_CLOCK_PHASE       2
`define SIF_C1_SELECT_OUTPUT_ENABLE       1
`define SIF_C1_LSBF       0

// ****************************************
// control two bit positions and write mask
// ****************************************
`define SIF_C2_MATCH_MASK 7
`define SIF_C2_FDET_EN    4
`define SIF_C2_SHARED_OE  3
`define SIF_C2_STOP_WAIT  1
`define SIF_C2_SINGLE_PIN 0
`define SIF_C2_WMASK      8'h9B

// ****************************************
// baud fields and write mask
// ****************************************
`define SIF_BR_PRE_HI     6
`define SIF_BR_PRE_LO     4
`define SIF_BR_RATE_HI    3
`define SIF_BR_RATE_LO    0
`define SIF_BR_WMASK      8'h7F

// ****************************************
// status bit positions
// ****************************************
`define SIF_ST_RXF        7
`define SIF_ST_MATCH      6
`define SIF_ST_TXE        5
`define SIF_ST_FAULT      4

// ****************************************
// reset values and counts
// ****************************************
`define SIF_RST_CTL1      8'h04
`define SIF_RST_CTL2      8'h00
`define SIF_RST_BAUD      8'h00
`define SIF_RST_CMP       8'h00
`define SIF_LAST_EDGE     4'hF

`endif

//--- include/sif_pkg.sv
package sif_pkg;

	// ****************************************
	// engine phase
	// ****************************************
	typedef enum logic [0:0]
	{
		SIF_IDLE = 1'b0,
		SIF_RUN  = 1'b1
	} sif_phase_t;

	// ****************************************
	// pin drive bundle
	// ****************************************
	typedef struct packed
	{
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic ss_n_o;
		logic ss_n_oe;
	} sif_pins_t;

	// ****************************************
	// whole block state
	// ****************************************
	typedef struct packed
	{
		logic [7:0]  ctl1;
		logic [7:0]  ctl2;
		logic [7:0]  baud;
		logic [7:0]  cmp;
		logic [7:0]  txbuf;
		logic [7:0]  rxbuf;
		logic [7:0]  txs;
		logic [7:0]  rxs;
		logic [7:0]  rdata;
		logic        rxf;
		logic        mtf;
		logic        txe;
		logic        mdf;
		logic        arm_rx;
		logic        arm_mt;
		logic        arm_tx;
		logic        arm_md;
		logic        pend;
		sif_phase_t  ph;
		logic [3:0]  edge_cnt;
		logic [11:0] div;
		logic [2:0]  sck_s;
		logic [2:0]  ss_s;
		logic [1:0]  mosi_s;
		logic [1:0]  miso_s;
		sif_pins_t   pins;
		logic        irq;
	} sif_state_t;

endpackage

//--- rtl/sif_port.sv
// Summary of operation
// RULE_01: receive-full and fault flags reach the interrupt only with the general mask set.
// RULE_02: transmit-empty flag reaches the interrupt only with the transmit mask set.
// RULE_03: match flag reaches the interrupt only with the match mask set.
// RULE_04: one interrupt line rises when any flag meets its mask; else flags are polled.
// RULE_05: software checks flags for the cause and clears them early in its handler.
// RULE_06: a master seeing select low sets fault, aborts and drops master select.
// RULE_07: the fault interrupt holds while the fault flag holds; clearing removes it.
// RULE_08: receive-full is set when a new byte lands in the receive buffer.
// RULE_09: a byte finishing while receive-full is still set is thrown away.
// RULE_10: transmit-empty is set once the transmit buffer can take a byte.
// RULE_11: match flag is set when the receive buffer equals the compare value.
// RULE_12: software sets control one, control two, baud, then compare, in that order.
// RULE_13: status read with transmit-empty, then data write, starts a master transfer.
// RULE_14: control one holds masks, enable, master, polarity, phase, select out, lsb first.
// RULE_15: polarity picks idle clock level, phase the edge use, lsb-first the bit order.
// RULE_16: control two holds match mask, fault enable, shared oe, stop-in-wait, single pin.
// RULE_17: single pin shares one data line; shared oe gives its direction; wait may freeze.
// RULE_18: baud holds prescale in 6:4 and rate in 3:0; bit 7 reads zero.
// RULE_19: all-zero baud gives a master clock of the bus clock over two.
// RULE_20: status shows receive-full, match, transmit-empty, fault in bits 7 to 4.
// RULE_21: compare register holds an eight-bit value checked against received bytes.
// RULE_22: one data address writes the transmit buffer and reads the receive buffer.
// RULE_23: status read with fault set, then control one write, clears the fault flag.
// RULE_24: with fault detect off or as slave, select is ignored and no fault arises.
// RULE_25: no interrupt is raised while the system enable bit is clear.
// RULE_26: status read then data read clears receive-full; then data write clears tx-empty.
//
// The implementer's own choices: the register offsets and the strobed register port.
`include "sif_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sif_port
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [2:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output wire logic [7:0]        reg_rdata,
	input  wire logic              cpu_wait,
	input  wire logic              sck_i,
	input  wire logic              mosi_i,
	input  wire logic              miso_i,
	input  wire logic              ss_n_i,
	output wire sif_pkg::sif_pins_t pin_out,
	output wire logic              irq
);

	// ****************************************
	// state
	// ****************************************
	sif_pkg::sif_state_t q;
	sif_pkg::sif_state_t n;

	// ****************************************
	// decoded control from the current state
	// ****************************************
	logic        system_enable_bit;
	logic        mst;
	logic        clock_polarity;
	logic        clock_phase;
	logic        lsbf;
	logic        select_output_enable;
	logic        fdet;
	logic        bidir;
	logic        frozen;
	logic        tick;
	logic        sck_edge;
	logic        ss_fall;
	logic        run_edge;
	logic        e_sample;
	logic        e_drive;
	logic        din;
	logic        fault;
	logic        done;
	logic [7:0]  rx_next;
	logic [7:0]  rx_fin;
	logic [7:0]  tx_shift;
	logic [11:0] pre1;
	logic [11:0] half_c;

	// control bit fields
	assign system_enable_bit   = q.ctl1[`SIF_C1_SYS_EN];
	assign mst   = q.ctl1[`SIF_C1_MASTER];
	assign clock_polarity  = q.ctl1[`SIF_C1_CLOCK_POLARITY];
	assign clock_phase  = q.ctl1[`SIF_C1_CLOCK_PHASE];
	assign lsbf  = q.ctl1[`SIF_C1_LSBF];
	assign select_output_enable  = q.ctl1[`SIF_C1_SELECT_OUTPUT_ENABLE];
	assign fdet  = q.ctl2[`SIF_C2_FDET_EN];
	assign bidir = q.ctl2[`SIF_C2_SINGLE_PIN];

	// half bit time = (prescale + 1) << rate; reserved large rates wrap to zero width
	assign pre1   = {9'h000, q.baud[`SIF_BR_PRE_HI:`SIF_BR_PRE_LO]} + 12'h001; // RULE_18
	assign half_c = pre1 << q.baud[`SIF_BR_RATE_HI:`SIF_BR_RATE_LO]; // RULE_19

	// master clock freezes in wait only when stop-in-wait is set
	assign frozen = q.ctl2[`SIF_C2_STOP_WAIT] && cpu_wait; // RULE_17
	assign tick   = (q.div == 12'h001) && !frozen;

	// edges are seen on the second and third sync stages only
	assign sck_edge = q.sck_s[1] ^ q.sck_s[2];
	assign ss_fall  = q.ss_s[2] && !q.ss_s[1];
	assign run_edge = (q.ph == sif_pkg::SIF_RUN) && (mst ? tick : sck_edge);

	// phase decides which edges sample and which drive
	assign e_sample = clock_phase ? q.edge_cnt[0] : !q.edge_cnt[0]; // RULE_15
	assign e_drive  = clock_phase ? (!q.edge_cnt[0] && (q.edge_cnt != 4'h0))
		: (q.edge_cnt[0] && (q.edge_cnt != `SIF_LAST_EDGE)); // RULE_15

	// data input pin depends on role and single-pin mode
	assign din = mst ? (bidir ? q.mosi_s[1] : q.miso_s[1])
		: (bidir ? q.miso_s[1] : q.mosi_s[1]); // RULE_17

	// bit order follows lsb-first select
	assign rx_next  = lsbf ? {din, q.rxs[7:1]} : {q.rxs[6:0], din}; // RULE_15
	assign tx_shift = lsbf ? {1'b0, q.txs[7:1]} : {q.txs[6:0], 1'b0};
	assign rx_fin   = e_sample ? rx_next : q.rxs;

	// select low while master with detect on and select not driven by us
	assign fault = system_enable_bit && mst && fdet && !select_output_enable && !q.ss_s[1]; // RULE_24
	assign done  = run_edge && (q.edge_cnt == `SIF_LAST_EDGE) && !fault;

	// ****************************************
	// next state
	// ****************************************
	logic       rx_set;
	logic       mt_set;
	logic       txe_set;
	logic       n_spe;
	logic       n_mst;
	logic       n_bidir;
	logic       n_dir;
	logic       n_out;
	logic       n_live;

	// one process computes everything; flag sets always win over software clears
	always_comb
	begin
		n       = q;
		rx_set  = 1'b0;
		mt_set  = 1'b0;
		txe_set = 1'b0;
		n.sck_s  = {q.sck_s[1:0], sck_i};
		n.ss_s   = {q.ss_s[1:0], ss_n_i};
		n.mosi_s = {q.mosi_s[0], mosi_i};
		n.miso_s = {q.miso_s[0], miso_i};

		// transfer engine
		if (!system_enable_bit || fault)
		begin
			n.ph       = sif_pkg::SIF_IDLE; // RULE_06
			n.edge_cnt = 4'h0;
			n.pins.sck_o = clock_polarity;
		end
		else
		begin
			case (q.ph)
				sif_pkg::SIF_IDLE:
				begin
					n.edge_cnt = 4'h0;
					n.pins.sck_o = clock_polarity; // RULE_15
					if (mst && q.pend)
					begin
						n.txs   = q.txbuf; // RULE_13
						n.pend  = 1'b0;
						txe_set = 1'b1; // RULE_10
						n.ph    = sif_pkg::SIF_RUN;
						n.div   = half_c;
						n.rxs   = 8'h00;
					end
					else if (!mst && ss_fall)
					begin
						if (q.pend)
						begin
							n.txs   = q.txbuf;
							n.pend  = 1'b0;
							txe_set = 1'b1; // RULE_10
						end
						n.ph  = sif_pkg::SIF_RUN;
						n.rxs = 8'h00;
					end
				end
				sif_pkg::SIF_RUN:
				begin
					if (!mst && q.ss_s[1])
					begin
						// deselect mid byte drops the partial byte
						n.ph = sif_pkg::SIF_IDLE;
					end
					else if (run_edge)
					begin
						if (mst)
						begin
							n.pins.sck_o = !q.pins.sck_o;
						end
						if (e_sample)
						begin
							n.rxs = rx_next;
						end
						if (e_drive)
						begin
							n.txs = tx_shift;
						end
						if (q.edge_cnt == `SIF_LAST_EDGE)
						begin
							n.ph = sif_pkg::SIF_IDLE;
							if (!q.rxf) // RULE_09
							begin
								n.rxbuf = rx_fin; // RULE_08
								rx_set  = 1'b1; // RULE_08
								mt_set  = (rx_fin == q.cmp); // RULE_11
							end
						end
						else
						begin
							n.edge_cnt = q.edge_cnt + 4'h1;
							n.div      = half_c;
						end
					end
					else if (mst && !frozen)
					begin
						n.div = q.div - 12'h001;
					end
				end
				default:
				begin
					n.ph = sif_pkg::SIF_IDLE;
				end
			endcase
		end

		// register writes
		if (reg_wr)
		begin
			case (reg_addr)
				`SIF_OFF_CTL1:
				begin
					n.ctl1 = reg_wdata; // RULE_14
					if (q.arm_md && !fault)
					begin
						n.mdf = 1'b0; // RULE_23
					end
					n.arm_md = 1'b0;
				end
				`SIF_OFF_CTL2:
				begin
					n.ctl2 = reg_wdata & `SIF_C2_WMASK; // RULE_16
				end
				`SIF_OFF_BAUD:
				begin
					n.baud = reg_wdata & `SIF_BR_WMASK; // RULE_18
				end
				`SIF_OFF_CMP:
				begin
					n.cmp = reg_wdata; // RULE_21
					if (q.arm_mt && !mt_set)
					begin
						n.mtf = 1'b0;
					end
					n.arm_mt = 1'b0;
				end
				`SIF_OFF_DATA:
				begin
					// a full buffer refuses the byte rather than corrupting a pending one
					if (q.txe)
					begin
						n.txbuf = reg_wdata; // RULE_22
						n.pend  = 1'b1; // RULE_13
						if (q.arm_tx && !txe_set)
						begin
							n.txe = 1'b0; // RULE_26
						end
					end
					n.arm_tx = 1'b0;
				end
				default:
				begin
				end
			endcase
		end

		// register reads: status arms the clears, data read consumes receive-full
		n.rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`SIF_OFF_CTL1:
				begin
					n.rdata = q.ctl1;
				end
				`SIF_OFF_CTL2:
				begin
					n.rdata = q.ctl2;
				end
				`SIF_OFF_BAUD:
				begin
					n.rdata = q.baud;
				end
				`SIF_OFF_STAT:
				begin
					n.rdata  = {q.rxf, q.mtf, q.txe, q.mdf, 4'h0}; // RULE_20
					n.arm_rx = q.rxf;
					n.arm_mt = q.mtf;
					n.arm_tx = q.txe;
					n.arm_md = q.mdf;
				end
				`SIF_OFF_CMP:
				begin
					n.rdata = q.cmp;
				end
				`SIF_OFF_DATA:
				begin
					n.rdata = q.rxbuf; // RULE_22
					if (q.arm_rx && !rx_set)
					begin
						n.rxf = 1'b0; // RULE_26
					end
					n.arm_rx = 1'b0;
				end
				default:
				begin
					n.rdata = 8'h00;
				end
			endcase
		end

		// hardware sets last so they win over clears
		if (rx_set)
		begin
			n.rxf = 1'b1; // RULE_08
		end
		if (mt_set)
		begin
			n.mtf = 1'b1; // RULE_11
		end
		if (txe_set)
		begin
			n.txe = 1'b1; // RULE_10
		end
		if (fault)
		begin
			n.mdf = 1'b1; // RULE_06
			n.ctl1[`SIF_C1_MASTER] = 1'b0; // RULE_06
		end

		// single request line, gated by system enable
		n.irq = n.ctl1[`SIF_C1_SYS_EN] && ( // RULE_25
			(n.ctl1[`SIF_C1_RXF_MASK] && (n.rxf || n.mdf)) || // RULE_01 RULE_07
			(n.ctl1[`SIF_C1_TX_MASK] && n.txe) || // RULE_02
			(n.ctl2[`SIF_C2_MATCH_MASK] && n.mtf)); // RULE_03 RULE_04

		// pin drive from the next state so every pin leaves a flip-flop
		n_spe   = n.ctl1[`SIF_C1_SYS_EN];
		n_mst   = n.ctl1[`SIF_C1_MASTER];
		n_bidir = n.ctl2[`SIF_C2_SINGLE_PIN];
		n_dir   = !n_bidir || n.ctl2[`SIF_C2_SHARED_OE]; // RULE_17
		n_out   = n.ctl1[`SIF_C1_LSBF] ? n.txs[0] : n.txs[7];
		// after a fault every line floats until the flag is cleared
		n_live  = n_spe && !n.mdf;
		n.pins.sck_oe  = n_live && n_mst;
		n.pins.mosi_o  = n_out;
		n.pins.mosi_oe = n_live && n_mst && n_dir;
		n.pins.miso_o  = n_out;
		n.pins.miso_oe = n_live && !n_mst && !n.ss_s[1] && n_dir;
		n.pins.ss_n_oe = n_live && n_mst && n.ctl1[`SIF_C1_SELECT_OUTPUT_ENABLE] && n.ctl2[`SIF_C2_FDET_EN];
		n.pins.ss_n_o  = (n.ph != sif_pkg::SIF_RUN);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.ctl1 <= `SIF_RST_CTL1;
			q.ctl2 <= `SIF_RST_CTL2;
			q.baud <= `SIF_RST_BAUD;
			q.cmp  <= `SIF_RST_CMP;
			q.txe  <= 1'b1;
			q.ss_s <= 3'h7;
			q.sck_s <= 3'h0;
			q.pins.ss_n_o <= 1'b1;
		end
		else
		begin
			q <= n;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = q.rdata;
	assign pin_out   = q.pins;
	assign irq       = q.irq;

	// ****************************************
	// checks
	// ****************************************
	a_rx_irq_path: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
		(q.rxf && system_enable_bit && q.ctl1[`SIF_C1_RXF_MASK] && !reg_wr && !reg_rd) |=> irq)
		else $error("receive-full with mask did not raise irq");

	a_tx_irq_path: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
		(q.txe && system_enable_bit && q.ctl1[`SIF_C1_TX_MASK] && !reg_wr && !reg_rd) |=> irq)
		else $error("transmit-empty with mask did not raise irq");

	a_match_irq_path: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
		(q.mtf && system_enable_bit && q.ctl2[`SIF_C2_MATCH_MASK] && !reg_wr && !reg_rd) |=> irq)
		else $error("match with mask did not raise irq");

	a_irq_has_cause: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
		irq |-> (q.ctl1[`SIF_C1_RXF_MASK] && (q.rxf || q.mdf))
		|| (q.ctl1[`SIF_C1_TX_MASK] && q.txe) || (q.ctl2[`SIF_C2_MATCH_MASK] && q.mtf))
		else $error("irq without a masked flag");

	a_fault_aborts: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_06
		$rose(q.mdf) |-> !q.ctl1[`SIF_C1_MASTER] && (q.ph == sif_pkg::SIF_IDLE))
		else $error("fault left master set or transfer running");

	a_fault_irq_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_07
		(q.mdf && system_enable_bit && q.ctl1[`SIF_C1_RXF_MASK]) [*2] |-> irq)
		else $error("fault irq dropped while flag set");

	a_rx_set_copy: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
		$changed(q.rxbuf) |-> $rose(q.rxf))
		else $error("receive buffer changed without raising receive-full");

	a_rx_overrun: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_09
		(q.rxf && $past(q.rxf)) |-> $stable(q.rxbuf))
		else $error("receive buffer overwritten while full");

	a_fast_clock: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_19
		(q.ph == sif_pkg::SIF_RUN && mst && system_enable_bit && !fdet && !frozen && q.baud == 8'h00
		&& $past(q.baud) == 8'h00 && !reg_wr) |=> $changed(q.pins.sck_o))
		else $error("zero baud master clock not at half bus rate");

	a_slave_no_fault: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_24
		$rose(q.mdf) |-> $past(mst) && $past(fdet) && !$past(select_output_enable))
		else $error("fault raised outside detecting master");

	a_irq_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_25
		(!system_enable_bit && !reg_wr) |=> !irq)
		else $error("irq raised while disabled");

	a_status_low_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_20
		(reg_rd && reg_addr == `SIF_OFF_STAT) |=> (q.rdata[3:0] == 4'h0) ##1 ($past(reg_rd) || (q.rdata == 8'h00)))
		else $error("status low bits or idle read data not zero");

endmodule

`default_nettype wire

//--- verification/sif_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// external serial slave, clock phase one, msb first
// ****************************************
module sif_slave_model
(
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	output var  logic       miso,
	output var  logic [7:0] rx_byte,
	output var  int         edges
);
	int bit_n;

	initial
	begin
		miso = 1'b0;
		rx_byte = 8'h00;
		edges = 0;
		bit_n = 0;
	end

	// leading edge launches the next bit, so the master has half a period to sync it
	always @(posedge sck)
	begin
		miso <= tx_byte[7 - bit_n];
		edges <= edges + 1;
	end

	// trailing edge captures; 100 ns after the last bit the line is inverted
	always @(negedge sck)
	begin
		rx_byte <= {rx_byte[6:0], mosi};
		edges <= edges + 1;
		bit_n = (bit_n + 1) % 8;
		if (bit_n == 0)
		begin
			#100 miso = ~miso;
		end
	end
endmodule
`default_nettype wire

//--- verification/spi_interrupt_flags_and_setup_tb_top.sv
`include "sif_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_interrupt_flags_and_setup_tb_top;
	logic               sys_clk;
	logic               rst_n;
	logic [2:0]         reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	wire  logic [7:0]   reg_rdata;
	wire  logic         irq;
	wire  sif_pkg::sif_pins_t pin_out;
	wire  logic         slv_miso;
	wire  logic [7:0]   slv_rx;
	int                 edges;
	logic               cpu_wait;
	logic [7:0]         slv_tx;
	logic               ss_drv;
	logic [7:0]         d;
	int                 num_errors;
	int                 samples_checked;

	// ****************************************
	// wire resolution and instances
	// ****************************************
	// undriven clock and mosi read low, undriven miso reads the slave; select has the bench as second driver
	wire logic sck_w  = pin_out.sck_oe ? pin_out.sck_o : 1'b0;
	wire logic mosi_w = pin_out.mosi_oe ? pin_out.mosi_o : 1'b0;
	wire logic miso_w = pin_out.miso_oe ? pin_out.miso_o : slv_miso;
	wire logic ss_w   = pin_out.ss_n_oe ? pin_out.ss_n_o : ss_drv;

	sif_port u_sif_port
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.cpu_wait  (cpu_wait),
		.sck_i     (sck_w),
		.mosi_i    (mosi_w),
		.miso_i    (miso_w),
		.ss_n_i    (ss_w),
		.pin_out   (pin_out),
		.irq       (irq)
	);

	sif_slave_model u_sif_slave_model
	(
		.sck     (sck_w),
		.mosi    (mosi_w),
		.tx_byte (slv_tx),
		.miso    (slv_miso),
		.rx_byte (slv_rx),
		.edges   (edges)
	);

	always #20 sys_clk = ~sys_clk;

	// ****************************************
	// bus cycles and comparisons
	// ****************************************
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk($sformatf("reg%0d", a), exp, v);
	endtask

	task automatic chk_irq(input logic exp);
		repeat (3) @(posedge sys_clk);
		#1 chk("irq", {7'h00, exp}, {7'h00, irq});
	endtask

	// waits for the slave to see n clock edges, bounded
	task automatic wait_edges(input int n);
		int e0;
		e0 = edges;
		for (int i = 0; i < 2000 && (edges - e0) < n; i++)
			@(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic close_out;
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_map;
		logic [7:0] exp [7] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++)
			chk_reg(3'(i), exp[i]);
		wr(`SIF_OFF_CTL2, 8'hFF);
		wr(`SIF_OFF_BAUD, 8'hFF);
		wr(`SIF_OFF_CMP, 8'hA5);
		wr(`SIF_OFF_STAT, 8'hFF);
		chk_reg(`SIF_OFF_CTL2, 8'h9B);
		chk_reg(`SIF_OFF_BAUD, 8'h7F);
		chk_reg(`SIF_OFF_CMP, 8'hA5);
		chk_reg(`SIF_OFF_STAT, 8'h20);
	endtask

	// master at full rate: one clock toggle per bus cycle
	task automatic t_fast;
		int e0;
		int n;
		wr(`SIF_OFF_CTL1, 8'h54);
		wr(`SIF_OFF_CTL2, 8'h00);
		wr(`SIF_OFF_BAUD, 8'h00);
		wr(`SIF_OFF_CMP, 8'h3C);
		rd(`SIF_OFF_STAT, d);
		e0 = edges;
		n = 0;
		wr(`SIF_OFF_DATA, 8'hA5);
		for (int i = 0; i < 400 && (edges - e0) < 16; i++)
		begin
			@(posedge sys_clk);
			#1 if (edges - e0 > 0 && edges - e0 < 16) n++;
		end
		chk("half periods", 8'h0F, 8'(n));
		repeat (8) @(posedge sys_clk);
		chk("slave rx", 8'hA5, slv_rx);
		rd(`SIF_OFF_STAT, d);
		rd(`SIF_OFF_DATA, d);
		wr(`SIF_OFF_CMP, 8'h3C);
		chk_reg(`SIF_OFF_STAT, 8'h20);
	endtask

	// the byte is queued while the divider is frozen in wait, then released
	task automatic t_receive;
		int e0;
		wr(`SIF_OFF_BAUD, 8'h03);
		wr(`SIF_OFF_CTL2, 8'h02);
		cpu_wait <= 1'b1;
		slv_tx = 8'h3C;
		rd(`SIF_OFF_STAT, d);
		e0 = edges;
		wr(`SIF_OFF_DATA, 8'h5A);
		repeat (40) @(posedge sys_clk);
		chk("frozen edges", 8'h00, 8'(edges - e0));
		cpu_wait <= 1'b0;
		wr(`SIF_OFF_CTL2, 8'h00);
		wait_edges(16);
		chk("slave rx", 8'h5A, slv_rx);
		chk_reg(`SIF_OFF_DATA, 8'h3C);
		chk_reg(`SIF_OFF_STAT, 8'hE0);
		chk_irq(1'b0);
		wr(`SIF_OFF_CTL1, 8'hD4);
		chk_irq(1'b1);
		wr(`SIF_OFF_CTL1, 8'h74);
		chk_irq(1'b1);
		wr(`SIF_OFF_CTL1, 8'h54);
		wr(`SIF_OFF_CTL2, 8'h80);
		chk_irq(1'b1);
		wr(`SIF_OFF_CTL2, 8'h00);
		chk_irq(1'b0);
	endtask

	// second byte queued behind a running one, both finish with receive-full still set
	task automatic t_overrun;
		slv_tx = 8'h99;
		rd(`SIF_OFF_STAT, d);
		wr(`SIF_OFF_DATA, 8'h11);
		repeat (10) @(posedge sys_clk);
		rd(`SIF_OFF_STAT, d);
		wr(`SIF_OFF_DATA, 8'h22);
		chk_reg(`SIF_OFF_STAT, 8'hC0);
		wait_edges(32);
		chk("slave rx", 8'h22, slv_rx);
		chk_reg(`SIF_OFF_STAT, 8'hE0);
		chk_reg(`SIF_OFF_DATA, 8'h3C);
		chk_reg(`SIF_OFF_STAT, 8'h60);
	endtask

	task automatic t_fault;
		@(posedge sys_clk) ss_drv <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_reg(`SIF_OFF_STAT, 8'h60);
		@(posedge sys_clk) ss_drv <= 1'b1;
		wr(`SIF_OFF_CTL2, 8'h10);
		wr(`SIF_OFF_CTL1, 8'hD4);
		@(posedge sys_clk) ss_drv <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_reg(`SIF_OFF_STAT, 8'h70);
		chk_reg(`SIF_OFF_CTL1, 8'hC4);
		chk("pin drive", 8'h00, {4'h0, pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe, pin_out.ss_n_oe});
		chk_irq(1'b1);
		@(posedge sys_clk) ss_drv <= 1'b1;
		rd(`SIF_OFF_STAT, d);
		wr(`SIF_OFF_CTL1, 8'hD4);
		chk_reg(`SIF_OFF_STAT, 8'h60);
		chk("pin drive", 8'h0C, {4'h0, pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe, pin_out.ss_n_oe});
		chk_irq(1'b0);
		wr(`SIF_OFF_CTL1, 8'h34);
		chk_irq(1'b0);
		// select output on with detect enabled: the block drives select high while idle
		wr(`SIF_OFF_CTL1, 8'h76);
		chk_irq(1'b1);
		chk("select drive", 8'h03, {6'h00, pin_out.ss_n_oe, pin_out.ss_n_o});
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slv_tx = 8'hC3;
		ss_drv = 1'b1;
		cpu_wait = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset_map();
		t_fast();
		t_receive();
		t_overrun();
		t_fault();
		close_out();
	end

	// the whole run is under three thousand cycles; this leaves ample room
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		close_out();
	end
endmodule
`default_nettype wire
